/* reload_timers_regs.svh */
// Register offsets, field positions, reset values and rate constants
// Assumes a 100 MHz system clock and byte-wide register access
`ifndef RELOAD_TIMERS_REGS_SVH
`define RELOAD_TIMERS_REGS_SVH

`define ADDR_B_CTRL 8'h19
`define ADDR_B_RLD_HI 8'h1a
`define ADDR_B_RLD_LO 8'h1b
`define ADDR_B_CNT_HI 8'h1c
`define ADDR_B_CNT_LO 8'h1d
`define ADDR_C_CTRL 8'h1e
`define ADDR_C_RLD_HI 8'h1f
`define ADDR_C_RLD_LO 8'h20
`define ADDR_C_CNT_HI 8'h21
`define ADDR_C_CNT_LO 8'h22
`define ADDR_IRQ_STATUS 8'h40
`define ADDR_IRQ_MASK 8'h41
`define ADDR_COMMAND 8'h42

`define CTRL_STOP_RX_BIT 7
`define CTRL_START_MSB 5
`define CTRL_START_LSB 4
`define CTRL_AUTO_BIT 3
`define CTRL_CLK_MSB 1
`define CTRL_CLK_LSB 0

`define CMD_STOP_OFS 2

`define RST_CTRL 6'h00
`define RST_RELOAD 8'h00
`define RST_BYTE 8'h00

`define SYS_CLK_HZ 100000000
`define FAST_CLK_HZ 13560000
`define SLOW_C_CLK_HZ 211875
`define SLOW_B_CLK_HZ 212000
`define ACC_BITS 24
`define TICK_STEP(hz) 24'((64'(hz) << `ACC_BITS) / 64'(`SYS_CLK_HZ))

`endif

/* reload_timers_pkg.sv */
// Types shared by the reload timer block
// Assumes the offsets and fields of reload_timers_regs.svh
package reload_timers_pkg;

  typedef enum logic [1:0] {
    START_NONE = 2'b00,
    START_TX_END = 2'b01,
    START_TRIM = 2'b10,
    START_TRIM_UF = 2'b11
  } start_mode_t;

  typedef enum logic [1:0] {
    CLK_FAST = 2'b00,
    CLK_SLOW = 2'b01,
    CLK_T0_UF = 2'b10,
    CLK_T1_UF = 2'b11
  } clk_sel_t;

  typedef struct packed {
    logic stop_on_receive;
    start_mode_t start_mode;
    logic auto_reload_enable;
    clk_sel_t count_clock_select;
  } timer_ctrl_t;

endpackage

/* tick_divider.sv */
// Fractional rate divider making one-cycle tick enables
// Assumes the 100 MHz system clock; STEP = rate * 2^24 / clock
`include "reload_timers_regs.svh"
module tick_divider #(
  parameter logic [`ACC_BITS-1:0] STEP = `TICK_STEP(`FAST_CLK_HZ)
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  output logic o_tick
);
  logic [`ACC_BITS-1:0] acc_ff;
  logic [`ACC_BITS:0] nxt_sum;

  assign nxt_sum = {1'b0, acc_ff} + {1'b0, STEP};

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_ff <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_sum[`ACC_BITS-1:0];
      o_tick <= nxt_sum[`ACC_BITS];
    end
  end
endmodule // tick_divider

/* reload_countdown_timers.sv */
// Two 16-bit reload down-counters (timer b, timer c) with register port
// Assumes same-clock event inputs; the oscillator pin is asynchronous
//
// Operation
// - A start event loads the counter with the high and low reload bytes joined.
// - Writing a reload byte leaves a running count alone until the next start, or until an auto reload at zero.
// - The live count is read as separate high and low bytes.
// - With stop-on-receive set the timer halts once the first 4 bits arrive.
// - In trimming modes stop-on-receive has no effect.
// - Start mode 00 never starts by itself; 01 starts at end of transmission.
// - Start modes 10 and 11 trim against the oscillator, starting and stopping on rising edges.
// - With auto reload set the timer reloads and continues on each zero, except in start mode 10, where it stops at zero.
// - With auto reload clear the timer stops at zero until the next start.
// - Each underflow sets the timer's interrupt request flag.
// - Clock select 00 counts at 13.56 MHz and 01 at the slow rate.
// - Clock select 10 and 11 count underflows of the outer timers zero and one.
// - Timer c is a 16-bit down-counter readable as high and low bytes.
// - Timer b has the same control fields, its slow rate being 212 kHz.
`include "reload_timers_regs.svh"
module reload_countdown_timers (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_tx_end,
  input wire logic i_rx_first4,
  input wire logic i_lfo,
  input wire logic i_t0_underflow,
  input wire logic i_t1_underflow,
  output logic [7:0] o_rdata,
  output logic o_irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic reload_timers_pkg::timer_ctrl_t byte_to_ctrl(
    input logic [7:0] b
  );
    reload_timers_pkg::timer_ctrl_t c;
    c.stop_on_receive = b[`CTRL_STOP_RX_BIT];
    c.start_mode =
      reload_timers_pkg::start_mode_t'(b[`CTRL_START_MSB:`CTRL_START_LSB]);
    c.auto_reload_enable = b[`CTRL_AUTO_BIT];
    c.count_clock_select =
      reload_timers_pkg::clk_sel_t'(b[`CTRL_CLK_MSB:`CTRL_CLK_LSB]);
    byte_to_ctrl = c;
  endfunction

  function automatic logic [7:0] ctrl_to_byte(
    input reload_timers_pkg::timer_ctrl_t c
  );
    // Reserved bits 6 and 2 stay zero
    ctrl_to_byte = {c.stop_on_receive, 1'b0, c.start_mode,
                    c.auto_reload_enable, 1'b0, c.count_clock_select};
  endfunction

  function automatic logic pick_tick(
    input reload_timers_pkg::clk_sel_t s,
    input logic fast,
    input logic slow,
    input logic uf0,
    input logic uf1
  );
    case (s)
      reload_timers_pkg::CLK_FAST: pick_tick = fast;
      reload_timers_pkg::CLK_SLOW: pick_tick = slow;
      reload_timers_pkg::CLK_T0_UF: pick_tick = uf0;
      reload_timers_pkg::CLK_T1_UF: pick_tick = uf1;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  localparam logic [7:0] CTRL_ADDR [2] = '{`ADDR_B_CTRL, `ADDR_C_CTRL};
  localparam logic [7:0] RHI_ADDR [2] = '{`ADDR_B_RLD_HI, `ADDR_C_RLD_HI};
  localparam logic [7:0] RLO_ADDR [2] = '{`ADDR_B_RLD_LO, `ADDR_C_RLD_LO};

  // ----------------------------------------
  // Tick dividers
  // ----------------------------------------
  logic tick_fast;
  logic tick_slow [2];

  tick_divider #(
    .STEP(`TICK_STEP(`FAST_CLK_HZ))
  ) u_fast_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_tick(tick_fast)
  );

  tick_divider #(
    .STEP(`TICK_STEP(`SLOW_B_CLK_HZ))
  ) u_slow_b_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_tick(tick_slow[0])
  );

  tick_divider #(
    .STEP(`TICK_STEP(`SLOW_C_CLK_HZ))
  ) u_slow_c_div (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .o_tick(tick_slow[1])
  );

  // ----------------------------------------
  // Oscillator pin sync and edge
  // ----------------------------------------
  logic lfo_meta_ff;
  logic lfo_sync_ff;
  logic lfo_prev_ff;
  logic lfo_rise;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lfo_meta_ff <= 1'b0;
      lfo_sync_ff <= 1'b0;
      lfo_prev_ff <= 1'b0;
    end
    else
    begin
      lfo_meta_ff <= i_lfo;
      lfo_sync_ff <= lfo_meta_ff;
      lfo_prev_ff <= lfo_sync_ff;
    end
  end

  assign lfo_rise = lfo_sync_ff & ~lfo_prev_ff;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  reload_timers_pkg::timer_ctrl_t ctrl_ff [2];
  logic [7:0] rld_hi_ff [2];
  logic [7:0] rld_lo_ff [2];
  logic [1:0] mask_ff;
  logic cmd_wr;

  assign cmd_wr = i_wr && (i_addr == `ADDR_COMMAND);

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int t = 0; t < 2; t++)
      begin
        ctrl_ff[t] <= `RST_CTRL;
        rld_hi_ff[t] <= `RST_RELOAD;
        rld_lo_ff[t] <= `RST_RELOAD;
      end
    end
    else if (i_wr)
    begin
      for (int t = 0; t < 2; t++)
      begin
        if (i_addr == CTRL_ADDR[t])
          ctrl_ff[t] <= byte_to_ctrl(i_wdata);
        // only the holding byte changes here
        if (i_addr == RHI_ADDR[t])
          rld_hi_ff[t] <= i_wdata;
        if (i_addr == RLO_ADDR[t])
          rld_lo_ff[t] <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      mask_ff <= 2'h0;
    else if (i_wr && (i_addr == `ADDR_IRQ_MASK))
      mask_ff <= i_wdata[1:0];
  end

  // ----------------------------------------
  // Countdown timers
  // ----------------------------------------
  logic [15:0] count_ff [2];
  logic [15:0] reload_val [2];
  logic [1:0] running_ff;
  logic [1:0] uf_ff;
  logic [1:0] tick;
  logic [1:0] start_ev;
  logic [1:0] stop_ev;
  logic [1:0] at_zero;
  logic [1:0] trim;
  logic [1:0] trim_no_uf;

  for (genvar t = 0; t < 2; t++)
  begin : g_timer
    // reload value is both bytes joined
    assign reload_val[t] = {rld_hi_ff[t], rld_lo_ff[t]};
    assign trim[t] = ctrl_ff[t].start_mode[1];
    assign trim_no_uf[t] = ctrl_ff[t].start_mode == reload_timers_pkg::START_TRIM;
    assign at_zero[t] = count_ff[t] == 16'h0000;
    assign tick[t] = pick_tick(ctrl_ff[t].count_clock_select, tick_fast,
                               tick_slow[t], i_t0_underflow, i_t1_underflow);
    assign start_ev[t] = (cmd_wr && i_wdata[t])
      || (ctrl_ff[t].start_mode == reload_timers_pkg::START_TX_END && i_tx_end)
      || (trim[t] && lfo_rise && !running_ff[t]);
    assign stop_ev[t] = (cmd_wr && i_wdata[t+`CMD_STOP_OFS])
      || (trim[t] && lfo_rise && running_ff[t])
      || (!trim[t] && ctrl_ff[t].stop_on_receive && i_rx_first4);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
      if (!i_rstn)
        count_ff[t] <= 16'h0000;
      else if (start_ev[t])
        count_ff[t] <= reload_val[t];
      else if (running_ff[t] && !stop_ev[t] && tick[t])
      begin
        if (at_zero[t] && ctrl_ff[t].auto_reload_enable && !trim_no_uf[t])
          count_ff[t] <= reload_val[t];
        else if (!at_zero[t])
          count_ff[t] <= count_ff[t] - 16'h0001;
      end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
      if (!i_rstn)
        running_ff[t] <= 1'b0;
      else if (start_ev[t])
        running_ff[t] <= 1'b1;
      else if (stop_ev[t])
        running_ff[t] <= 1'b0;
      // halt at zero without auto reload
      else if (tick[t] && at_zero[t]
               && (!ctrl_ff[t].auto_reload_enable || trim_no_uf[t]))
        running_ff[t] <= 1'b0;
    end

    // underflow pulse, none in trimming without underflow
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
      if (!i_rstn)
        uf_ff[t] <= 1'b0;
      else
        uf_ff[t] <= running_ff[t] && tick[t] && at_zero[t]
                    && !trim_no_uf[t] && !start_ev[t] && !stop_ev[t];
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [1:0] status_ff;
  logic [1:0] nxt_status;

  always_comb
  begin
    nxt_status = status_ff;
    if (i_wr && (i_addr == `ADDR_IRQ_STATUS))
      nxt_status = status_ff & ~i_wdata[1:0];
    nxt_status = nxt_status | uf_ff;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      status_ff <= 2'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      o_irq <= |(nxt_status & mask_ff);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= `RST_BYTE;
    else if (!i_rd)
      o_rdata <= `RST_BYTE;
    else
    begin
      case (i_addr)
        `ADDR_B_CTRL: o_rdata <= ctrl_to_byte(ctrl_ff[0]);
        `ADDR_B_RLD_HI: o_rdata <= rld_hi_ff[0];
        `ADDR_B_RLD_LO: o_rdata <= rld_lo_ff[0];
        `ADDR_B_CNT_HI: o_rdata <= count_ff[0][15:8];
        `ADDR_B_CNT_LO: o_rdata <= count_ff[0][7:0];
        `ADDR_C_CTRL: o_rdata <= ctrl_to_byte(ctrl_ff[1]);
        `ADDR_C_RLD_HI: o_rdata <= rld_hi_ff[1];
        `ADDR_C_RLD_LO: o_rdata <= rld_lo_ff[1];
        `ADDR_C_CNT_HI: o_rdata <= count_ff[1][15:8];
        `ADDR_C_CNT_LO: o_rdata <= count_ff[1][7:0];
        `ADDR_IRQ_STATUS: o_rdata <= {6'h00, status_ff};
        `ADDR_IRQ_MASK: o_rdata <= {6'h00, mask_ff};
        `ADDR_COMMAND: o_rdata <= {6'h00, running_ff};
        default: o_rdata <= `RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  for (genvar t = 0; t < 2; t++)
  begin : g_chk
    sequence s_quiet;
      !start_ev[t] && !stop_ev[t];
    endsequence

    sequence s_trim_edge;
      trim[t] && !running_ff[t] ##0 lfo_rise;
    endsequence

    a_reload_on_start: assert property (
      start_ev[t] |=> count_ff[t] == $past(reload_val[t]))
      else $error("count not loaded on start");

    a_reload_write_quiet: assert property (
      (i_wr && (i_addr == RLO_ADDR[t] || i_addr == RHI_ADDR[t]) && !tick[t])
      and s_quiet |=> $stable(count_ff[t]))
      else $error("reload write disturbed count");

    a_stop_on_rx: assert property (
      running_ff[t] && ctrl_ff[t].stop_on_receive && !trim[t]
      && i_rx_first4 && !start_ev[t] |=> !running_ff[t])
      else $error("timer ran on after four bits");

    a_trim_ignores_rx: assert property (
      (running_ff[t] && trim[t] && i_rx_first4 && !(tick[t] && at_zero[t]))
      and s_quiet |=> running_ff[t])
      else $error("receive stopped a trimming timer");

    a_tx_end_start: assert property (
      ctrl_ff[t].start_mode == reload_timers_pkg::START_TX_END
      && i_tx_end |=> running_ff[t])
      else $error("no start at end of transmission");

    a_no_auto_start: assert property (
      ctrl_ff[t].start_mode == reload_timers_pkg::START_NONE
      && !running_ff[t] && !(cmd_wr && i_wdata[t]) |=> !running_ff[t])
      else $error("timer started without a cause");

    a_trim_edge_start: assert property (
      s_trim_edge |=> running_ff[t] ##0 count_ff[t] == $past(reload_val[t]))
      else $error("trim edge did not start timer");

    a_auto_restart: assert property (
      (running_ff[t] && tick[t] && at_zero[t] && ctrl_ff[t].auto_reload_enable
      && !trim_no_uf[t]) and s_quiet
      |=> running_ff[t] && count_ff[t] == $past(reload_val[t]))
      else $error("auto reload failed");

    // stop at zero without auto reload
    a_stop_at_zero: assert property (
      running_ff[t] && tick[t] && at_zero[t]
      && !ctrl_ff[t].auto_reload_enable && !start_ev[t]
      |=> !running_ff[t] ##1 (!running_ff[t] || $past(start_ev[t])))
      else $error("timer did not stop at zero");

    // underflow sets the flag within two cycles
    a_irq_flag_set: assert property (
      (running_ff[t] && tick[t] && at_zero[t] && !trim_no_uf[t]) and s_quiet
      |=> ##1 status_ff[t])
      else $error("underflow flag not set");

    a_cascade_hold: assert property (
      (running_ff[t] && ctrl_ff[t].count_clock_select
      == reload_timers_pkg::CLK_T0_UF && !i_t0_underflow) and s_quiet
      |=> $stable(count_ff[t]))
      else $error("cascaded count moved without underflow");

    a_tick_decrement: assert property (
      (running_ff[t] && tick[t] && !at_zero[t]) and s_quiet
      |=> count_ff[t] == $past(count_ff[t]) - 16'h0001)
      else $error("count did not step down");

    a_fast_select: assert property (
      (running_ff[t] && ctrl_ff[t].count_clock_select
      == reload_timers_pkg::CLK_FAST && !tick_fast) and s_quiet
      |=> $stable(count_ff[t]))
      else $error("fast source counted without a tick");
  end

  a_count_hi_read: assert property (
    i_rd && i_addr == `ADDR_C_CNT_HI |=> o_rdata == $past(count_ff[1][15:8]))
    else $error("count high byte wrong");

  a_count_lo_read: assert property (
    i_rd && i_addr == `ADDR_C_CNT_LO |=> o_rdata == $past(count_ff[1][7:0]))
    else $error("count low byte wrong");

  a_b_ctrl_read: assert property (
    i_rd && i_addr == `ADDR_B_CTRL
    |=> o_rdata == $past(ctrl_to_byte(ctrl_ff[0])))
    else $error("timer b control readback wrong");

  a_reserved_zero: assert property (
    i_rd && (i_addr == `ADDR_B_CTRL || i_addr == `ADDR_C_CTRL)
    |=> o_rdata[6] == 1'b0 && o_rdata[2] == 1'b0)
    else $error("reserved control bit set");

endmodule // reload_countdown_timers

/* tb.sv */
// Self-checking bench for the two reload down-counters and their register port
// Assumes the register offsets of reload_timers_regs.svh and a 100 MHz clock
`include "reload_timers_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk;
  logic i_rstn;
  logic i_wr;
  logic i_rd;
  logic i_lfo;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic [3:0] evt;
  logic [7:0] o_rdata;
  logic o_irq;
  logic [7:0] d;
  int error_cnt;
  int tests_run;

  // Event lanes: 0 timer zero uf, 1 timer one uf, 2 tx end, 3 first four bits
  reload_countdown_timers u_dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_tx_end(evt[2]),
    .i_rx_first4(evt[3]),
    .i_lfo(i_lfo),
    .i_t0_underflow(evt[0]),
    .i_t1_underflow(evt[1]),
    .o_rdata(o_rdata),
    .o_irq(o_irq)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Access and checking tasks
  // ----------------------------------------
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task rc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] v;
    rd(a, v);
    check(n, v, e);
  endtask

  // Hold the selected event lanes high for n edges
  task pulse(input logic [3:0] m, input int n);
    @(posedge i_clk);
    evt <= m;
    repeat (n) @(posedge i_clk);
    evt <= 4'h0;
    repeat (3) @(posedge i_clk);
  endtask

  // Oscillator level, then time for the synchroniser
  task low_freq_oscillator(input logic v);
    @(posedge i_clk);
    i_lfo <= v;
    repeat (5) @(posedge i_clk);
  endtask

  task irq_is(input logic e, input string n);
    repeat (2) @(posedge i_clk);
    #1;
    check(n, {7'h00, o_irq}, {7'h00, e});
  endtask

  task test_done;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    $display("Error watchdog expected end seen hang");
    error_cnt++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_lfo = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    evt = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;

    rc(`ADDR_C_CTRL, 8'h00, "c_ctrl_reset");
    rc(`ADDR_C_RLD_HI, 8'h00, "c_reload_hi_reset");
    rc(`ADDR_C_CNT_HI, 8'h00, "c_count_hi_reset");
    rc(8'h30, 8'h00, "unmapped_read");
    wr(`ADDR_C_CTRL, 8'hff);
    rc(`ADDR_C_CTRL, 8'hbb, "c_ctrl_reserved");
    wr(`ADDR_C_CNT_HI, 8'hff);
    rc(`ADDR_C_CNT_HI, 8'h00, "c_count_hi_ro");
    $display("Test registers done");

    wr(`ADDR_IRQ_MASK, 8'h03);
    wr(`ADDR_C_CTRL, 8'h02);
    wr(`ADDR_C_RLD_HI, 8'h01);
    wr(`ADDR_C_RLD_LO, 8'h02);
    wr(`ADDR_COMMAND, 8'h02);
    rc(`ADDR_C_CNT_HI, 8'h01, "c_load_hi");
    rc(`ADDR_C_CNT_LO, 8'h02, "c_load_lo");
    pulse(4'h1, 1);
    rc(`ADDR_C_CNT_LO, 8'h01, "c_t0_tick");
    pulse(4'h2, 1);
    rc(`ADDR_C_CNT_LO, 8'h01, "c_t1_ignored");
    wr(`ADDR_C_RLD_LO, 8'h55);
    rc(`ADDR_C_CNT_LO, 8'h01, "c_reload_no_disturb");
    wr(`ADDR_COMMAND, 8'h08);
    wr(`ADDR_COMMAND, 8'h02);
    rc(`ADDR_C_CNT_LO, 8'h55, "c_reload_next_start");
    rc(`ADDR_C_CNT_HI, 8'h01, "c_reload_next_hi");
    $display("Test cascade done");

    wr(`ADDR_C_RLD_HI, 8'h00);
    wr(`ADDR_C_RLD_LO, 8'h02);
    wr(`ADDR_COMMAND, 8'h02);
    pulse(4'h1, 2);
    rc(`ADDR_COMMAND, 8'h02, "c_running_at_zero");
    irq_is(1'b0, "irq_before_uf");
    pulse(4'h1, 1);
    rc(`ADDR_COMMAND, 8'h00, "c_stopped_after_uf");
    rc(`ADDR_IRQ_STATUS, 8'h02, "c_uf_flag");
    irq_is(1'b1, "irq_raised");
    pulse(4'h1, 2);
    rc(`ADDR_COMMAND, 8'h00, "c_stays_stopped");
    wr(`ADDR_IRQ_STATUS, 8'h02);
    irq_is(1'b0, "irq_cleared");
    $display("Test expiry done");

    wr(`ADDR_IRQ_MASK, 8'h00);
    wr(`ADDR_C_CTRL, 8'h0b);
    wr(`ADDR_COMMAND, 8'h02);
    pulse(4'h2, 3);
    rc(`ADDR_COMMAND, 8'h02, "c_auto_running");
    rc(`ADDR_C_CNT_LO, 8'h02, "c_auto_reloaded");
    rc(`ADDR_IRQ_STATUS, 8'h02, "c_auto_flag");
    irq_is(1'b0, "irq_masked");
    wr(`ADDR_IRQ_MASK, 8'h02);
    irq_is(1'b1, "irq_unmasked");
    wr(`ADDR_IRQ_STATUS, 8'h02);
    wr(`ADDR_COMMAND, 8'h08);
    $display("Test auto reload done");

    wr(`ADDR_C_CTRL, 8'h02);
    pulse(4'h4, 1);
    rc(`ADDR_COMMAND, 8'h00, "c_mode00_no_start");
    wr(`ADDR_C_CTRL, 8'h12);
    pulse(4'h4, 1);
    rc(`ADDR_COMMAND, 8'h02, "c_mode01_start");
    pulse(4'h8, 1);
    rc(`ADDR_COMMAND, 8'h02, "c_rx_no_stop");
    wr(`ADDR_C_CTRL, 8'h92);
    pulse(4'h8, 1);
    rc(`ADDR_COMMAND, 8'h00, "c_rx_stop");
    $display("Test start and stop done");

    wr(`ADDR_C_CTRL, 8'ha2);
    low_freq_oscillator(1'b1);
    rc(`ADDR_COMMAND, 8'h02, "c_trim_start");
    pulse(4'h8, 1);
    rc(`ADDR_COMMAND, 8'h02, "c_trim_rx_ignored");
    low_freq_oscillator(1'b0);
    low_freq_oscillator(1'b1);
    rc(`ADDR_COMMAND, 8'h00, "c_trim_stop");
    low_freq_oscillator(1'b0);
    low_freq_oscillator(1'b1);
    pulse(4'h1, 3);
    rc(`ADDR_COMMAND, 8'h00, "c_trim_zero_stop");
    rc(`ADDR_IRQ_STATUS, 8'h00, "c_trim_no_uf");
    wr(`ADDR_C_CTRL, 8'hb2);
    low_freq_oscillator(1'b0);
    low_freq_oscillator(1'b1);
    pulse(4'h1, 3);
    rc(`ADDR_IRQ_STATUS, 8'h02, "c_trim_uf");
    wr(`ADDR_IRQ_STATUS, 8'h02);
    wr(`ADDR_COMMAND, 8'h08);
    $display("Test trimming done");

    wr(`ADDR_C_CTRL, 8'h00);
    wr(`ADDR_C_RLD_HI, 8'h01);
    wr(`ADDR_C_RLD_LO, 8'h00);
    wr(`ADDR_COMMAND, 8'h02);
    repeat (100) @(posedge i_clk);
    rd(`ADDR_C_CNT_LO, d);
    check("c_fast_rate", {7'h00, (d >= 8'hf1 && d <= 8'hf4)}, 8'h01);
    wr(`ADDR_C_CTRL, 8'h01);
    wr(`ADDR_COMMAND, 8'h02);
    repeat (1000) @(posedge i_clk);
    rd(`ADDR_C_CNT_LO, d);
    check("c_slow_rate", {7'h00, (d >= 8'hfd && d <= 8'hff)}, 8'h01);
    wr(`ADDR_COMMAND, 8'h08);
    $display("Test clock rates done");

    wr(`ADDR_B_RLD_HI, 8'h00);
    wr(`ADDR_B_RLD_LO, 8'h05);
    wr(`ADDR_B_CTRL, 8'h03);
    rc(`ADDR_B_RLD_LO, 8'h05, "b_reload_lo_rw");
    rc(`ADDR_B_CTRL, 8'h03, "b_ctrl_rw");
    wr(`ADDR_COMMAND, 8'h01);
    pulse(4'h2, 2);
    rc(`ADDR_B_CNT_LO, 8'h03, "b_count_lo");
    rc(`ADDR_B_CNT_HI, 8'h00, "b_count_hi");
    rc(`ADDR_COMMAND, 8'h01, "b_running");
    wr(`ADDR_COMMAND, 8'h04);
    rc(`ADDR_COMMAND, 8'h00, "b_stopped");
    wr(`ADDR_COMMAND, 8'h01);
    pulse(4'h2, 6);
    rc(`ADDR_COMMAND, 8'h00, "b_stop_at_zero");
    rc(`ADDR_IRQ_STATUS, 8'h01, "b_uf_flag");
    $display("Test timer b done");

    test_done();
  end
endmodule // tb
